// File: inc/hwx_pkg.sv
// Shared constants, encodings and carrier types for the halfword extend and hint decoder
package hwx_pkg;

  // Opcode masks and patterns; 16-bit forms sit in the low half of the word
  localparam logic [31:0] HWX_T1_XTH_MASK  = 32'h0000_FFC0;
  localparam logic [31:0] HWX_T1_XTH_PAT   = 32'h0000_B280;
  localparam logic [31:0] HWX_T1_HINT_MASK = 32'h0000_FFFF;
  localparam logic [31:0] HWX_T1_EVT_PAT   = 32'h0000_BF20;
  localparam logic [31:0] HWX_T1_INT_PAT   = 32'h0000_BF30;
  localparam logic [31:0] HWX_T1_YLD_PAT   = 32'h0000_BF10;
  localparam logic [31:0] HWX_T2_XTH_MASK  = 32'hFFFF_F080;
  localparam logic [31:0] HWX_T2_XTH_PAT   = 32'hFA1F_F080;
  localparam logic [31:0] HWX_T2_HINT_MASK = 32'hFFF0_D7FF;
  localparam logic [31:0] HWX_T2_EVT_PAT   = 32'hF3A0_8002;
  localparam logic [31:0] HWX_T2_INT_PAT   = 32'hF3A0_8003;
  localparam logic [31:0] HWX_T2_YLD_PAT   = 32'hF3A0_8001;

  // Operand field positions and widths
  localparam int          HWX_T1_RM_LSB  = 3;
  localparam int          HWX_T1_RD_LSB  = 0;
  localparam int          HWX_T1_REG_W   = 3;
  localparam int          HWX_T2_RM_LSB  = 0;
  localparam int          HWX_T2_RD_LSB  = 8;
  localparam int          HWX_T2_ROT_LSB = 4;
  localparam int          HWX_ROT_FLD_W  = 2;
  localparam logic [2:0]  HWX_ROT_PAD    = 3'h0;
  localparam logic [4:0]  HWX_ROT_0      = 5'h00;
  localparam logic [4:0]  HWX_ROT_8      = 5'h08;
  localparam logic [4:0]  HWX_ROT_16     = 5'h10;
  localparam logic [4:0]  HWX_ROT_24     = 5'h18;
  localparam logic [3:0]  HWX_REG_SP     = 4'hD;
  localparam logic [3:0]  HWX_REG_PC     = 4'hF;

  // Priority compare; zero base priority means no base masking
  localparam logic [7:0]  HWX_BASE_OFF   = 8'h00;

  // Register map (byte addresses)
  localparam int          HWX_ADDR_W     = 12;
  localparam logic [11:0] HWX_ADDR_CTRL  = 12'h000;
  localparam logic [11:0] HWX_ADDR_STAT  = 12'h004;
  localparam logic [11:0] HWX_ADDR_FLAG  = 12'h008;
  localparam logic [11:0] HWX_ADDR_CNT   = 12'h00C;
  localparam int          HWX_CTRL_YLD   = 0;
  localparam int          HWX_CTRL_BLK   = 1;
  localparam int          HWX_FLAG_UNP   = 0;
  localparam int          HWX_FLAG_EVT   = 1;
  localparam int          HWX_STAT_EVT   = 2;
  localparam int          HWX_STAT_UNP   = 3;
  localparam int          HWX_STAT_SLP   = 4;
  localparam logic [15:0] HWX_CNT_STEP   = 16'h0001;

  typedef enum logic [1:0] {
    HWX_IDLE      = 2'h0,
    HWX_EXEC      = 2'h1,
    HWX_SLEEP_INT = 2'h3,
    HWX_SLEEP_EVT = 2'h2
  } hwx_state_e;

  typedef enum logic [2:0] {
    HWX_OP_NONE = 3'h0,
    HWX_OP_XTH  = 3'h1,
    HWX_OP_EVT  = 3'h2,
    HWX_OP_INT  = 3'h3,
    HWX_OP_YLD  = 3'h4
  } hwx_op_e;

  typedef struct packed {
    logic        valid;
    logic        cond_pass;
    logic        is32;
    logic [31:0] word;
  } hwx_instr_s;

  typedef struct packed {
    hwx_op_e    op;
    logic [3:0] rd;
    logic [3:0] rm;
    logic [4:0] rot;
    logic       unpred;
  } hwx_dec_s;

  typedef struct packed {
    logic       pend;
    logic [7:0] pend_prio;
    logic [7:0] active_prio;
    logic [7:0] exec_prio;
    logic [7:0] base_priority_level;
    logic       priority_mask_bit;
    logic       fault_mask_bit;
  } hwx_exc_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  rd;
    logic [31:0] data;
  } hwx_wb_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } hwx_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } hwx_apb_rsp_s;

endpackage

// File: src/hwx_decode.sv
// Opcode match and operand field extraction for extend and hint forms
`timescale 1ns/10ps
`default_nettype none
module hwx_decode
  import hwx_pkg::*;
(
  input  wire logic [31:0]       WORD,
  input  wire logic              IS32,
  output hwx_pkg::hwx_dec_s      DEC
);

  function automatic logic hit(input logic [31:0] w, input logic [31:0] m, input logic [31:0] p);
    return (w & m) == p;
  endfunction

  function automatic logic banned(input logic [3:0] r);
    return (r == HWX_REG_SP) || (r == HWX_REG_PC);
  endfunction

  logic [31:0] w16;

  assign w16 = {16'h0000, WORD[15:0]};

  // Should-be bits are left out of every mask
  // Fixed bits only
  always_comb begin
    DEC = '0;
    DEC.op = HWX_OP_NONE;
    if (!IS32) begin
      if (hit(w16, HWX_T1_XTH_MASK, HWX_T1_XTH_PAT)) begin
        DEC.op = HWX_OP_XTH;
        DEC.rm = {1'b0, WORD[HWX_T1_RM_LSB +: HWX_T1_REG_W]};
        DEC.rd = {1'b0, WORD[HWX_T1_RD_LSB +: HWX_T1_REG_W]};
        DEC.rot = HWX_ROT_0;
      end else if (hit(w16, HWX_T1_HINT_MASK, HWX_T1_EVT_PAT)) begin
        DEC.op = HWX_OP_EVT;
      end else if (hit(w16, HWX_T1_HINT_MASK, HWX_T1_INT_PAT)) begin
        DEC.op = HWX_OP_INT;
      end else if (hit(w16, HWX_T1_HINT_MASK, HWX_T1_YLD_PAT)) begin
        DEC.op = HWX_OP_YLD;
      end
    end else begin
      if (hit(WORD, HWX_T2_XTH_MASK, HWX_T2_XTH_PAT)) begin
        DEC.op = HWX_OP_XTH;
        DEC.rm = WORD[HWX_T2_RM_LSB +: 4];
        DEC.rd = WORD[HWX_T2_RD_LSB +: 4];
        DEC.rot = {WORD[HWX_T2_ROT_LSB +: HWX_ROT_FLD_W], HWX_ROT_PAD};
        DEC.unpred = banned(DEC.rm) || banned(DEC.rd);
      end else if (hit(WORD, HWX_T2_HINT_MASK, HWX_T2_EVT_PAT)) begin
        DEC.op = HWX_OP_EVT;
      end else if (hit(WORD, HWX_T2_HINT_MASK, HWX_T2_INT_PAT)) begin
        DEC.op = HWX_OP_INT;
      end else if (hit(WORD, HWX_T2_HINT_MASK, HWX_T2_YLD_PAT)) begin
        DEC.op = HWX_OP_YLD;
      end
    end
  end

endmodule
`default_nettype wire

// File: src/hwx_extend.sv
// Rotate right by a byte multiple and zero-extend the low halfword
`timescale 1ns/10ps
`default_nettype none
module hwx_extend
  import hwx_pkg::*;
(
  input  wire logic [31:0] SRC,
  input  wire logic [4:0]  ROT,
  output logic      [31:0] RESULT
);

  logic [31:0] rotated;

  always_comb begin
    case (ROT)
      HWX_ROT_8:  rotated = {SRC[7:0], SRC[31:8]};
      HWX_ROT_16: rotated = {SRC[15:0], SRC[31:16]};
      HWX_ROT_24: rotated = {SRC[23:0], SRC[31:24]};
      default:    rotated = SRC;
    endcase
  end

  assign RESULT = {16'h0000, rotated[15:0]};

endmodule
`default_nettype wire

// File: src/hwx_core.sv
// Execute unit for halfword zero-extend and the sleep and yield hints, with APB control
//
// Notes on behaviour
// - Short extend form: source bits 5:3, destination bits 2:0, no rotation.
// - Long extend form: rotation equals two-bit field with three zero bits appended.
// - Long extend form naming register 13 or 15 is unpredictable.
// - Rotate source right, write low halfword zero-extended to destination.
// - Rotation is only 0, 8, 16 or 24 bits.
// - Event hint: consume set event register, otherwise enter event sleep.
// - Event sleep ends on reset, any exception or another event.
// - Interrupt hint sleeps until reset, asynchronous exception or wake event.
// - Interrupt hint with failed condition completes without sleeping.
// - Priority mask set, fault mask clear: wake on exception above active and base.
// - Otherwise, exceptions not above execution priority are ignored and do not wake interrupt sleep.
// - Yield signals a thread scheduler when enabled, else has no effect.
// - Hint encodings need only the fixed opcode match.
`timescale 1ns/10ps
`default_nettype none
module hwx_core
  import hwx_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  ARST_N,
  input  wire hwx_pkg::hwx_instr_s   INSTR,
  output logic                       INSTR_READY,
  output logic [3:0]                 RF_RADDR,
  input  wire logic [31:0]           RF_RDATA,
  output hwx_pkg::hwx_wb_s           WB,
  output logic                       RETIRE,
  input  wire hwx_pkg::hwx_exc_s     EXC,
  input  wire logic                  EVENT_IN,
  input  wire logic                  WAKE_REQ,
  output logic                       SLEEP_ACTIVE,
  output logic                       SLEEP_ON_EVENT,
  output logic                       WAKE_PULSE,
  output logic                       YIELD_PULSE,
  input  wire hwx_pkg::hwx_apb_req_s APB_REQ,
  output hwx_pkg::hwx_apb_rsp_s      APB_RSP
);

  typedef struct packed {
    hwx_state_e  state;
    hwx_dec_s    dec;
    logic [3:0]  raddr;
    logic        event_reg;
    logic        unpred_flag;
    logic        yield_en;
    logic        unpred_block;
    logic [15:0] sleeps;
    hwx_wb_s     wb;
    logic        done;
    logic        yield_pulse;
    logic        wake_pulse;
    logic        sleep;
    logic        sleep_evt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hwx_core_s;

  hwx_core_s   r_reg;
  hwx_core_s   r_next;
  hwx_dec_s    dec;
  logic [31:0] ext_result;

  // Decode is combinational on the offered word; only accepted fields are kept
  hwx_decode u_decode (
    .WORD (INSTR.word),
    .IS32 (INSTR.is32),
    .DEC  (dec)
  );

  // Extend works on the registered fields and the register file's answer
  hwx_extend u_extend (
    .SRC    (RF_RDATA),
    .ROT    (r_reg.dec.rot),
    .RESULT (ext_result)
  );

  // Lower number means higher priority
  function automatic logic outranks(input logic [7:0] a, input logic [7:0] b);
    return a < b;
  endfunction

  function automatic logic int_wake(input hwx_exc_s e);
    logic base_ok;
    base_ok = (e.base_priority_level == HWX_BASE_OFF) || outranks(e.pend_prio, e.base_priority_level);
    // Masked: must beat every active exception and the base level
    if (e.priority_mask_bit && !e.fault_mask_bit) begin
      return e.pend && outranks(e.pend_prio, e.active_prio) && base_ok;
    end
    // Priority mask clear or fault mask set: anything not above execution priority leaves the core asleep
    return e.pend && outranks(e.pend_prio, e.exec_prio);
  endfunction

  // Sleep entry count wraps; software sees all sixteen bits
  function automatic logic [15:0] count_up(input logic [15:0] n);
    return n + HWX_CNT_STEP;
  endfunction

  // Write strobe for one mapped word, true only on the completing edge
  function automatic logic wr_hit(input logic wr, input logic [11:0] a, input logic [11:0] target);
    return wr && (a == target);
  endfunction

  logic        apb_setup;
  logic        apb_write;
  logic [11:0] apb_addr;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic        sw_evt_set;
  logic        sw_unp_clr;
  logic        evt_consume;
  logic        evt_wake;
  logic        unp_set;
  logic        flag_wr;
  logic        ctrl_wr;

  // Write acts on the access edge that follows a setup answered with ready
  assign apb_setup = APB_REQ.psel && !APB_REQ.penable;
  assign apb_write = APB_REQ.psel && APB_REQ.penable && r_reg.pready && APB_REQ.pwrite;
  assign apb_addr  = APB_REQ.paddr[HWX_ADDR_W-1:0];

  always_comb begin
    addr_ok = 1'b1;
    rd_word = '0;
    case (apb_addr)
      HWX_ADDR_CTRL: begin
        rd_word[HWX_CTRL_YLD] = r_reg.yield_en;
        rd_word[HWX_CTRL_BLK] = r_reg.unpred_block;
      end
      HWX_ADDR_STAT: begin
        rd_word[$bits(hwx_state_e)-1:0] = r_reg.state;
        rd_word[HWX_STAT_EVT] = r_reg.event_reg;
        rd_word[HWX_STAT_UNP] = r_reg.unpred_flag;
        rd_word[HWX_STAT_SLP] = r_reg.sleep;
      end
      HWX_ADDR_FLAG: begin
        rd_word[HWX_FLAG_UNP] = r_reg.unpred_flag;
        rd_word[HWX_FLAG_EVT] = r_reg.event_reg;
      end
      HWX_ADDR_CNT: begin
        rd_word[$bits(r_reg.sleeps)-1:0] = r_reg.sleeps;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  assign flag_wr    = wr_hit(apb_write, apb_addr, HWX_ADDR_FLAG);
  assign ctrl_wr    = wr_hit(apb_write, apb_addr, HWX_ADDR_CTRL);
  assign sw_evt_set = flag_wr && APB_REQ.pwdata[HWX_FLAG_EVT];
  assign sw_unp_clr = flag_wr && APB_REQ.pwdata[HWX_FLAG_UNP];

  always_comb begin
    r_next             = r_reg;
    r_next.done        = 1'b0;
    r_next.yield_pulse = 1'b0;
    r_next.wake_pulse  = 1'b0;
    r_next.wb.valid    = 1'b0;
    r_next.pready      = 1'b0;
    r_next.pslverr     = 1'b0;
    evt_consume        = 1'b0;
    evt_wake           = 1'b0;
    unp_set            = 1'b0;

    case (r_reg.state)
      HWX_IDLE: begin
        if (INSTR.valid) begin
          if (!INSTR.cond_pass) begin
            r_next.done = 1'b1;
          end else begin
            case (dec.op)
              HWX_OP_XTH: begin
                // Fields are held so the execute cycle does not depend on the offered word
                r_next.dec   = dec;
                r_next.raddr = dec.rm;
                r_next.state = HWX_EXEC;
                unp_set      = dec.unpred;
              end
              HWX_OP_EVT: begin
                if (r_reg.event_reg) begin
                  evt_consume = 1'b1;
                  r_next.done = 1'b1;
                end else begin
                  r_next.state     = HWX_SLEEP_EVT;
                  r_next.sleep     = 1'b1;
                  r_next.sleep_evt = 1'b1;
                  r_next.sleeps    = count_up(r_reg.sleeps);
                end
              end
              HWX_OP_INT: begin
                r_next.state  = HWX_SLEEP_INT;
                r_next.sleep  = 1'b1;
                r_next.sleeps = count_up(r_reg.sleeps);
              end
              HWX_OP_YLD: begin
                r_next.yield_pulse = r_reg.yield_en;
                r_next.done        = 1'b1;
              end
              default: begin
                r_next.done = 1'b1;
              end
            endcase
          end
        end
      end
      HWX_EXEC: begin
        // Write extended result
        // Result of an unpredictable form is dropped only when software asks for it
        r_next.wb.valid = !(r_reg.dec.unpred && r_reg.unpred_block);
        r_next.wb.rd    = r_reg.dec.rd;
        r_next.wb.data  = ext_result;
        r_next.done     = 1'b1;
        r_next.state    = HWX_IDLE;
      end
      HWX_SLEEP_EVT: begin
        if (EVENT_IN || EXC.pend || WAKE_REQ) begin
          // The waking event is used up here and is not left in the event register
          evt_wake          = EVENT_IN;
          r_next.state      = HWX_IDLE;
          r_next.sleep      = 1'b0;
          r_next.sleep_evt  = 1'b0;
          r_next.wake_pulse = 1'b1;
          r_next.done       = 1'b1;
        end
      end
      HWX_SLEEP_INT: begin
        if (int_wake(EXC) || WAKE_REQ) begin
          r_next.state      = HWX_IDLE;
          r_next.sleep      = 1'b0;
          r_next.wake_pulse = 1'b1;
          r_next.done       = 1'b1;
        end
      end
      default: begin
        r_next.state     = HWX_IDLE;
        r_next.sleep     = 1'b0;
        r_next.sleep_evt = 1'b0;
      end
    endcase

    // A new event beats the clear by a consuming hint
    if ((EVENT_IN && !evt_wake) || sw_evt_set) begin
      r_next.event_reg = 1'b1;
    end else if (evt_consume) begin
      r_next.event_reg = 1'b0;
    end

    // Sticky: a new unpredictable form beats a software clear in the same cycle
    if (unp_set) begin
      r_next.unpred_flag = 1'b1;
    end else if (sw_unp_clr) begin
      r_next.unpred_flag = 1'b0;
    end

    // Only the control and flag words are writable; status and count ignore writes
    if (ctrl_wr) begin
      r_next.yield_en     = APB_REQ.pwdata[HWX_CTRL_YLD];
      r_next.unpred_block = APB_REQ.pwdata[HWX_CTRL_BLK];
    end

    // Answer is prepared in the setup cycle, zero wait states
    // Read word is latched then, so the access cycle sees a stable value
    if (apb_setup) begin
      r_next.pready  = 1'b1;
      r_next.prdata  = rd_word;
      r_next.pslverr = !addr_ok;
    end
  end

  // Whole state resets to idle with every flag and count clear
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Ready is decoded from state so a held instruction is taken on the first idle edge
  assign INSTR_READY    = (r_reg.state == HWX_IDLE);
  assign RF_RADDR       = r_reg.raddr;
  assign WB             = r_reg.wb;
  assign RETIRE         = r_reg.done;
  assign SLEEP_ACTIVE   = r_reg.sleep;
  assign SLEEP_ON_EVENT = r_reg.sleep_evt;
  assign WAKE_PULSE     = r_reg.wake_pulse;
  assign YIELD_PULSE    = r_reg.yield_pulse;
  assign APB_RSP.pready  = r_reg.pready;
  assign APB_RSP.prdata  = r_reg.prdata;
  assign APB_RSP.pslverr = r_reg.pslverr;

endmodule
`default_nettype wire

// File: bench/hwx_core_sva.sv
// Concurrent checks on the extend and hint execute unit ports
`timescale 1ns/10ps
`default_nettype none
module hwx_core_sva
  import hwx_pkg::*;
(
  input wire logic                CLK_SYS,
  input wire logic                ARST_N,
  input wire hwx_pkg::hwx_instr_s INSTR,
  input wire logic                INSTR_READY,
  input wire logic [3:0]          RF_RADDR,
  input wire hwx_pkg::hwx_wb_s    WB,
  input wire logic                RETIRE,
  input wire hwx_pkg::hwx_exc_s   EXC,
  input wire logic                EVENT_IN,
  input wire logic                WAKE_REQ,
  input wire logic                SLEEP_ACTIVE,
  input wire logic                SLEEP_ON_EVENT,
  input wire logic                WAKE_PULSE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  logic take;
  logic short_xth;
  logic int_sleep;
  assign take = INSTR.valid && INSTR_READY;
  assign short_xth = take && INSTR.cond_pass && !INSTR.is32 && ((INSTR.word & HWX_T1_XTH_MASK) == HWX_T1_XTH_PAT);
  assign int_sleep = SLEEP_ACTIVE && !SLEEP_ON_EVENT;
  sequence s_wake;
    WAKE_PULSE && RETIRE && !SLEEP_ACTIVE;
  endsequence
  sequence s_short_wb;
    ##1 RF_RADDR == {1'b0, $past(INSTR.word[5:3])} ##1 WB.valid && WB.rd == {1'b0, $past(INSTR.word[2:0], 2)};
  endsequence
  short_extend_a: assert property (short_xth |-> s_short_wb)
    else $error("short extend fields wrong");
  zero_upper_a: assert property (WB.valid |-> WB.data[31:16] == 16'h0000)
    else $error("upper halfword not zero");
  cond_fail_a: assert property (take && !INSTR.cond_pass |=> RETIRE && !SLEEP_ACTIVE ##1 !WB.valid)
    else $error("failed condition had an effect");
  sleep_cause_a: assert property ($rose(SLEEP_ACTIVE) |-> $past(take))
    else $error("sleep without an instruction");
  sleep_blocks_a: assert property (SLEEP_ACTIVE |-> !INSTR_READY)
    else $error("instruction taken while asleep");
  event_wake_a: assert property (SLEEP_ON_EVENT && (EVENT_IN || EXC.pend || WAKE_REQ) |=> s_wake)
    else $error("event sleep did not end");
  int_wake_a: assert property (int_sleep && WAKE_REQ |=> s_wake)
    else $error("wake request ignored");
  mask_wake_a: assert property (int_sleep && EXC.pend && EXC.priority_mask_bit && !EXC.fault_mask_bit
    && EXC.pend_prio < EXC.active_prio && EXC.base_priority_level == HWX_BASE_OFF |=> s_wake)
    else $error("masked exception did not wake");
  low_prio_a: assert property (int_sleep && !WAKE_REQ && !EXC.priority_mask_bit
    && EXC.pend_prio >= EXC.exec_prio |=> SLEEP_ACTIVE)
    else $error("low priority exception woke");
endmodule
bind hwx_core hwx_core_sva hwx_core_sva_i (.CLK_SYS, .ARST_N, .INSTR, .INSTR_READY, .RF_RADDR, .WB, .RETIRE,
  .EXC, .EVENT_IN, .WAKE_REQ, .SLEEP_ACTIVE, .SLEEP_ON_EVENT, .WAKE_PULSE);
`default_nettype wire

// File: bench/hwx_rf_model.sv
// Register file model answering the source read of the extend unit
`timescale 1ns/10ps
`default_nettype none
module hwx_rf_model
  import hwx_pkg::*;
(
  input wire logic [3:0]  raddr,
  output logic     [31:0] rdata
);
  // Register n holds n in the top nibble so a wrong index shows in the result of a 16 or 24 bit rotation
  assign rdata = {raddr, 28'h1234567};
endmodule
`default_nettype wire

// File: bench/halfword_extend_and_hint_decoder_test.sv
// Self-checking bench for the halfword extend and hint execute unit
`timescale 1ns/10ps
`default_nettype none
module halfword_extend_and_hint_decoder_test;
  import hwx_pkg::*;
  typedef struct packed {
    logic        is32;
    logic [31:0] word;
    logic [3:0]  rd;
    logic [31:0] data;
  } hwx_row_s;
  localparam hwx_row_s ROWS [7] = '{
    '{1'b0, 32'h0000_B299, 4'h1, 32'h0000_4567},
    '{1'b0, 32'h0000_B2B7, 4'h7, 32'h0000_4567},
    '{1'b1, 32'hFA1F_FC8B, 4'hC, 32'h0000_4567},
    '{1'b1, 32'hFA1F_F294, 4'h2, 32'h0000_2345},
    '{1'b1, 32'hFA1F_F5A6, 4'h5, 32'h0000_6123},
    '{1'b1, 32'hFA1F_F7B8, 4'h7, 32'h0000_6781},
    '{1'b1, 32'hFA1F_F2D4, 4'h2, 32'h0000_2345}};
  logic         clk_sys = 1'b0;
  logic         arst_n;
  hwx_instr_s   instr;
  hwx_exc_s     exc;
  hwx_apb_req_s apb_req;
  hwx_apb_rsp_s apb_rsp;
  hwx_wb_s      wb;
  logic         instr_ready, retire, event_in, wake_req, sleep_active, sleep_on_event, wake_pulse, yield_pulse;
  logic [3:0]   rf_raddr;
  logic [31:0]  rf_rdata, rdat;
  logic         perr;
  int           errors, total_checks;

  always #2 clk_sys = ~clk_sys;

  hwx_core hwx_core_i (.CLK_SYS(clk_sys), .ARST_N(arst_n), .INSTR(instr), .INSTR_READY(instr_ready),
    .RF_RADDR(rf_raddr), .RF_RDATA(rf_rdata), .WB(wb), .RETIRE(retire), .EXC(exc), .EVENT_IN(event_in),
    .WAKE_REQ(wake_req), .SLEEP_ACTIVE(sleep_active), .SLEEP_ON_EVENT(sleep_on_event), .WAKE_PULSE(wake_pulse),
    .YIELD_PULSE(yield_pulse), .APB_REQ(apb_req), .APB_RSP(apb_rsp));
  hwx_rf_model hwx_rf_model_i (.raddr(rf_raddr), .rdata(rf_rdata));

  task automatic chk_word(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer an instruction and return on its accept edge
  task automatic issue(input logic cond, input logic is32, input logic [31:0] word);
    @(posedge clk_sys);
    instr <= '{1'b1, cond, is32, word};
    @(negedge clk_sys);
    while (!instr_ready) @(negedge clk_sys);
    @(posedge clk_sys);
    instr.valid <= 1'b0;
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdat);
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, wr, {20'h0, addr}, wdat};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Request stands until the edge that samples ready high; data is taken at that edge
    do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    perr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  // Wake cause was raised at the previous edge; drop it and expect the wake cycle
  task automatic woke;
    @(posedge clk_sys);
    event_in <= 1'b0;
    wake_req <= 1'b0;
    exc <= '0;
    @(negedge clk_sys);
    chk_bit(wake_pulse && retire && !sleep_active, 1'b1);
  endtask
  task automatic wb_after;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end

  initial begin
    arst_n = 1'b0;
    instr = '0;
    exc = '0;
    apb_req = '0;
    event_in = 1'b0;
    wake_req = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    chk_word({instr_ready, retire, sleep_active, wb.valid}, 40'h8);
    foreach (ROWS[i]) begin
      issue(1'b1, ROWS[i].is32, ROWS[i].word);
      wb_after();
      chk_word({wb.valid, wb.rd, wb.data}, {1'b1, ROWS[i].rd, ROWS[i].data});
    end
    issue(1'b1, 1'b1, 32'hFA1F_FD91);
    wb_after();
    chk_word({wb.valid, wb.rd, wb.data}, {1'b1, 4'hD, 32'h0000_2345});
    apb(1'b0, HWX_ADDR_FLAG, 32'h0);
    chk_bit(rdat[HWX_FLAG_UNP], 1'b1);
    apb(1'b1, HWX_ADDR_CTRL, 32'h2);
    issue(1'b1, 1'b1, 32'hFA1F_FD91);
    wb_after();
    chk_bit(wb.valid, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk_word({perr, rdat}, {1'b1, 32'h0});
    apb(1'b1, HWX_ADDR_FLAG, 32'h2);
    issue(1'b1, 1'b0, 32'h0000_BF20);
    @(negedge clk_sys);
    chk_bit(retire && !sleep_active, 1'b1);
    issue(1'b1, 1'b1, 32'hF3AF_8002);
    @(negedge clk_sys);
    chk_bit(sleep_on_event, 1'b1);
    @(posedge clk_sys);
    event_in <= 1'b1;
    woke();
    issue(1'b1, 1'b0, 32'h0000_BF20);
    @(posedge clk_sys);
    exc.pend <= 1'b1;
    woke();
    issue(1'b1, 1'b0, 32'h0000_BF30);
    @(negedge clk_sys);
    chk_bit(sleep_active && !sleep_on_event, 1'b1);
    @(posedge clk_sys);
    exc <= '{1'b1, 8'h40, 8'h80, 8'h40, HWX_BASE_OFF, 1'b0, 1'b0};
    repeat (3) @(negedge clk_sys);
    chk_bit(sleep_active, 1'b1);
    @(posedge clk_sys);
    exc.priority_mask_bit <= 1'b1;
    woke();
    issue(1'b1, 1'b1, 32'hF3A0_8003);
    @(posedge clk_sys);
    wake_req <= 1'b1;
    woke();
    issue(1'b0, 1'b0, 32'h0000_BF30);
    @(negedge clk_sys);
    chk_bit(retire && !sleep_active, 1'b1);
    apb(1'b1, HWX_ADDR_CTRL, 32'h1);
    issue(1'b1, 1'b0, 32'h0000_BF10);
    @(negedge clk_sys);
    chk_bit(yield_pulse && retire, 1'b1);
    apb(1'b1, HWX_ADDR_CTRL, 32'h0);
    issue(1'b1, 1'b1, 32'hF3A0_A001);
    @(negedge clk_sys);
    chk_bit(retire && !yield_pulse, 1'b1);
    apb(1'b0, HWX_ADDR_CNT, 32'h0);
    chk_word(rdat, 40'h4);
    issue(1'b1, 1'b0, 32'h0000_0000);
    @(negedge clk_sys);
    chk_bit(retire && !sleep_active && !wb.valid, 1'b1);
    apb(1'b1, HWX_ADDR_FLAG, 32'h1);
    issue(1'b1, 1'b0, 32'h0000_BF30);
    apb(1'b0, HWX_ADDR_STAT, 32'h0);
    chk_word(rdat, 40'h13);
    // Reset in mid-sleep must end the sleep and clear the count
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(negedge clk_sys);
    chk_word({instr_ready, retire, sleep_active, wb.valid}, 40'h8);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    apb(1'b0, HWX_ADDR_CNT, 32'h0);
    chk_word(rdat, 40'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
